// ==== verilog/servo_cycle_pkg.sv ====
package servo_cycle_pkg;
    // clock and cycle timing
    localparam int unsigned CLK_HZ = 25_000_000;
    localparam int unsigned CYCLE_US = 120;
    localparam int unsigned POLL_US = 40;
    localparam int unsigned CYCLE_CLKS = CYCLE_US * (CLK_HZ / 1_000_000);
    localparam int unsigned POLL_CLKS = POLL_US * (CLK_HZ / 1_000_000);
    localparam int unsigned POLLS_PER_CYCLE = CYCLE_US / POLL_US;
    localparam int unsigned SERIAL_BITS = 8;
    localparam int unsigned STATUS_WORDS = 3;
    // reset values
    localparam logic CONCURRENCY_RST = 1'b0;

    // task slots within one servo cycle, gray ordered
    typedef enum logic [2:0] {
        SLOT_IDLE = 3'b000,
        SLOT_LOOP = 3'b001,
        SLOT_PROG = 3'b011,
        SLOT_MOTION = 3'b010,
        SLOT_STATUS = 3'b110,
        SLOT_ERROR = 3'b111
    } slot_t;

    // hold state machine
    typedef enum logic [1:0] {
        HOLD_CLOSED = 2'b00,
        HOLD_SETTLE = 2'b01,
        HOLD_OPEN = 2'b11
    } hold_t;

    // hold configuration bundle
    typedef struct packed {
        logic [15:0] enter_err;
        logic [15:0] exit_err;
        logic check_torque;
        logic move_mode;
        logic [15:0] settle_cycles;
        logic [15:0] erl_cycles;
        logic [15:0] tq_moving;
        logic [15:0] tq_holding;
    } hold_cfg_t;

    // per-cycle task strobes
    typedef struct packed {
        logic serial_poll;
        logic loop_run;
        logic prog_run;
        logic motion_run;
        logic status_run;
        logic error_run;
    } task_strobe_t;
endpackage

// ==== verilog/servo_cycle_sequencer.sv ====
`timescale 1ns/1ps
`default_nettype none

module servo_cycle_sequencer #(
    parameter int unsigned CYCLE_LEN = servo_cycle_pkg::CYCLE_CLKS,
    parameter int unsigned POLL_LEN = servo_cycle_pkg::POLL_CLKS
) (
    input wire logic i_ref_clk,
    input wire logic i_srst,
    input wire servo_cycle_pkg::hold_cfg_t i_cfg, // hold thresholds, mode, timers, limits
    input wire logic [15:0] i_pos_err, // absolute position error, counts
    input wire logic [15:0] i_cl_torque, // closed loop torque in use
    input wire logic i_traj_active, // trajectory generator busy
    input wire logic i_stop_cond, // stop condition releases a stall
    input wire logic i_cmd_valid, // buffered program command waiting
    input wire logic i_cmd_is_motion, // that command is a motion command
    input wire logic i_cmd_is_wait, // that command is a delay or wait
    input wire logic i_cmd_wait_done, // delay or wait command complete
    input wire logic i_concurrency_on_cmd, // enable command executed
    input wire logic i_concurrency_off_cmd, // disable command executed
    input wire logic i_immediate_motion, // host immediate motion command
    input wire logic [7:0] i_serial_rx, // byte offered by serial link
    output servo_cycle_pkg::task_strobe_t o_task, // one-cycle task strobes
    output logic o_cmd_fetch, // take next buffered command
    output logic o_traj_start, // start the trajectory generator
    output logic o_concurrency, // concurrency flag
    output logic o_open_loop, // open-loop hold engaged
    output logic o_loop_update, // closed loop output update strobe
    output logic [15:0] o_torque_limit, // torque to apply in open loop
    output logic [7:0] o_serial_byte, // byte taken at the last poll
    output logic o_serial_take // poll strobe, byte captured
);

    // elaboration checks: the poll divider is realigned at every cycle start,
    // so the cycle must hold exactly three poll periods, and the slot
    // chain from loop to error must finish inside one poll period
    if (CYCLE_LEN != POLL_LEN * servo_cycle_pkg::POLLS_PER_CYCLE) begin : g_bad_cycle
        $error("cycle length must be three poll periods");
    end
    if (POLL_LEN < 8) begin : g_bad_poll
        $error("poll period too short for task slots");
    end

    localparam int unsigned CW = $clog2(CYCLE_LEN + 1);
    localparam int unsigned PW = $clog2(POLL_LEN + 1);

    logic [CW-1:0] cyc_cnt_r; // clocks within servo cycle
    logic [PW-1:0] poll_cnt_r; // clocks within poll period
    servo_cycle_pkg::slot_t slot_r; // current task slot
    logic cycle_start; // first clock of a cycle
    logic poll_tick; // first clock of a poll period

    // servo cycle divider
    // counts clocks inside one servo cycle; count zero is the cycle start,
    // which both kicks the slot chain and realigns the poll divider, so a
    // stray poll count can never drift against the cycle
    always_ff @(posedge i_ref_clk) begin
        if (i_srst) begin
            cyc_cnt_r <= '0;
        end else if (cyc_cnt_r == CW'(CYCLE_LEN - 1)) begin
            cyc_cnt_r <= '0;
        end else begin
            cyc_cnt_r <= cyc_cnt_r + 1'b1;
        end
    end

    // serial poll divider
    always_ff @(posedge i_ref_clk) begin
        if (i_srst) begin
            poll_cnt_r <= '0;
        end else if (poll_cnt_r == PW'(POLL_LEN - 1) || cycle_start) begin
            poll_cnt_r <= (cycle_start) ? PW'(1) : '0;
        end else begin
            poll_cnt_r <= poll_cnt_r + 1'b1;
        end
    end

    assign cycle_start = (cyc_cnt_r == '0);
    assign poll_tick = (poll_cnt_r == '0);

    // task slot sequencer: loop, program, motion, status, error
    // the chain runs once per cycle and then parks in idle; serial polling
    // runs on its own divider, so it is not a slot of the chain
    // illegal slot codes fall back to idle and wait for the next cycle start
    always_ff @(posedge i_ref_clk) begin
        if (i_srst) begin
            slot_r <= servo_cycle_pkg::SLOT_IDLE;
        end else begin
            unique case (slot_r)
                servo_cycle_pkg::SLOT_IDLE: begin
                    if (cycle_start) slot_r <= servo_cycle_pkg::SLOT_LOOP;
                end
                servo_cycle_pkg::SLOT_LOOP: slot_r <= servo_cycle_pkg::SLOT_PROG;
                servo_cycle_pkg::SLOT_PROG: slot_r <= servo_cycle_pkg::SLOT_MOTION;
                servo_cycle_pkg::SLOT_MOTION: slot_r <= servo_cycle_pkg::SLOT_STATUS;
                servo_cycle_pkg::SLOT_STATUS: slot_r <= servo_cycle_pkg::SLOT_ERROR;
                servo_cycle_pkg::SLOT_ERROR: slot_r <= servo_cycle_pkg::SLOT_IDLE;
                default: slot_r <= servo_cycle_pkg::SLOT_IDLE;
            endcase
        end
    end

    // serial byte capture every poll period
    always_ff @(posedge i_ref_clk) begin
        if (i_srst) begin
            o_serial_byte <= 8'h00;
            o_serial_take <= 1'b0;
        end else begin
            o_serial_take <= poll_tick;
            if (poll_tick) o_serial_byte <= i_serial_rx;
        end
    end

    // concurrency flag
    always_ff @(posedge i_ref_clk) begin
        if (i_srst) begin
            o_concurrency <= servo_cycle_pkg::CONCURRENCY_RST;
        end else if (i_concurrency_on_cmd) begin
            o_concurrency <= 1'b1;
        end else if (i_concurrency_off_cmd) begin
            o_concurrency <= 1'b0;
        end
    end

    // program stall after a motion command without concurrency
    // the stall is set by the fetch itself, because the generator only goes
    // busy after the motion slot of the next cycle; without it a second command could slip into
    // the gap between fetch and start
    // it clears when the motion slot sees the generator idle, even with the
    // fetched start still pending, or at once on a stop condition
    logic stall_r; // waiting for a motion slot with the generator idle
    logic prog_slot; // program task slot now
    logic motion_slot; // motion task slot now
    logic may_fetch; // program command allowed this cycle
    assign prog_slot = (slot_r == servo_cycle_pkg::SLOT_PROG);
    assign motion_slot = (slot_r == servo_cycle_pkg::SLOT_MOTION);
    // concurrency on: every cycle; off: only when generator idle and no stall
    assign may_fetch = i_cmd_valid
        && (o_concurrency || (!i_traj_active && !stall_r));

    always_ff @(posedge i_ref_clk) begin
        if (i_srst) begin
            stall_r <= 1'b0;
        end else if (o_cmd_fetch && i_cmd_is_motion && !o_concurrency) begin
            stall_r <= 1'b1;
        end else if (i_stop_cond || (motion_slot && !i_traj_active && !o_traj_start)) begin
            stall_r <= 1'b0;
        end
    end

    // wait commands hold the fetch until done
    logic waiting_r; // a delay or wait command in progress
    always_ff @(posedge i_ref_clk) begin
        if (i_srst) begin
            waiting_r <= 1'b0;
        end else if (o_cmd_fetch && i_cmd_is_wait) begin
            waiting_r <= 1'b1;
        end else if (i_cmd_wait_done || i_stop_cond) begin
            waiting_r <= 1'b0;
        end
    end

    // fetch strobe, at most one per cycle
    // only the program slot may fetch, which bounds fetches to one a cycle
    // a running delay or wait command blocks the fetch in either mode
    always_ff @(posedge i_ref_clk) begin
        if (i_srst) begin
            o_cmd_fetch <= 1'b0;
        end else begin
            o_cmd_fetch <= prog_slot && may_fetch && !waiting_r;
        end
    end

    // pending motion from program or host
    // a host motion can arrive at any clock; it waits here for the motion
    // slot so that starts always come in slot order
    logic motion_pend_r; // motion waiting for motion slot
    always_ff @(posedge i_ref_clk) begin
        if (i_srst) begin
            motion_pend_r <= 1'b0;
        end else if ((o_cmd_fetch && i_cmd_is_motion) || i_immediate_motion) begin
            motion_pend_r <= 1'b1;
        end else if (motion_slot) begin
            motion_pend_r <= 1'b0;
        end
    end

    // trajectory start strobe in motion slot
    always_ff @(posedge i_ref_clk) begin
        if (i_srst) begin
            o_traj_start <= 1'b0;
        end else begin
            o_traj_start <= motion_slot && motion_pend_r;
        end
    end

    // task strobes, one each per cycle except serial poll, which fires three times per cycle
    always_ff @(posedge i_ref_clk) begin
        if (i_srst) begin
            o_task <= '0;
        end else begin
            o_task.serial_poll <= poll_tick;
            o_task.loop_run <= (slot_r == servo_cycle_pkg::SLOT_LOOP);
            o_task.prog_run <= prog_slot;
            o_task.motion_run <= motion_slot;
            o_task.status_run <= (slot_r == servo_cycle_pkg::SLOT_STATUS);
            o_task.error_run <= (slot_r == servo_cycle_pkg::SLOT_ERROR);
        end
    end

    // closed loop update only when not in open-loop hold
    always_ff @(posedge i_ref_clk) begin
        if (i_srst) begin
            o_loop_update <= 1'b0;
        end else begin
            o_loop_update <= (slot_r == servo_cycle_pkg::SLOT_LOOP) && !o_open_loop;
        end
    end

    // open-loop hold machine, evaluated in loop slot
    // closed: waits for error within the entry threshold, a permitted mode
    // and, when asked, closed loop torque within the active limit
    // settle: counts the settle delay down once per cycle; any excess error
    // or torque reloads it, so the whole delay must pass cleanly
    // open: loads the error-limit timer on entry and counts it down; exit
    // depends on error, entry mode and the thresholds, not torque, and is taken at the next evaluation
    // thresholds both zero switch the feature off in every state
    // all counts are in servo cycles, not clocks, since evaluation happens
    // only in the loop slot
    servo_cycle_pkg::hold_t hold_r; // hold state
    logic [15:0] settle_r; // settle cycles remaining
    logic [15:0] erl_r; // error-limit cycles remaining
    logic eval; // once-per-cycle evaluation point
    logic feature_on; // thresholds not both zero
    logic err_ok; // error at or below entry threshold
    logic err_exit; // error at or above exit threshold
    logic mode_ok; // entry mode permits hold now
    logic torque_ok; // optional torque check passes
    logic [15:0] tq_lim; // active open loop limit

    assign eval = (slot_r == servo_cycle_pkg::SLOT_LOOP);
    assign feature_on = (i_cfg.enter_err != '0) || (i_cfg.exit_err != '0);
    assign err_ok = (i_pos_err <= i_cfg.enter_err);
    assign err_exit = (i_pos_err >= i_cfg.exit_err);
    assign mode_ok = i_cfg.move_mode || !i_traj_active;
    // moving limit before expiry, holding after
    assign tq_lim = (erl_r != '0 || hold_r != servo_cycle_pkg::HOLD_OPEN)
        ? i_cfg.tq_moving : i_cfg.tq_holding;
    assign torque_ok = !i_cfg.check_torque || (i_cl_torque <= tq_lim);

    always_ff @(posedge i_ref_clk) begin
        if (i_srst) begin
            hold_r <= servo_cycle_pkg::HOLD_CLOSED;
            settle_r <= 16'h0000;
            erl_r <= 16'h0000;
        end else if (eval) begin
            unique case (hold_r)
                servo_cycle_pkg::HOLD_CLOSED: begin
                    if (feature_on && err_ok && mode_ok && torque_ok) begin
                        hold_r <= servo_cycle_pkg::HOLD_SETTLE;
                        settle_r <= i_cfg.settle_cycles;
                    end
                end
                servo_cycle_pkg::HOLD_SETTLE: begin
                    if (!feature_on || !mode_ok) begin
                        hold_r <= servo_cycle_pkg::HOLD_CLOSED;
                    end else if (!err_ok || !torque_ok) begin
                        settle_r <= i_cfg.settle_cycles;
                    end else if (settle_r == '0) begin
                        hold_r <= servo_cycle_pkg::HOLD_OPEN;
                        erl_r <= i_cfg.erl_cycles;
                    end else begin
                        settle_r <= settle_r - 1'b1;
                    end
                end
                servo_cycle_pkg::HOLD_OPEN: begin
                    if (err_exit || !feature_on || !mode_ok) begin
                        hold_r <= servo_cycle_pkg::HOLD_CLOSED;
                        erl_r <= 16'h0000;
                    end else if (erl_r != '0) begin
                        erl_r <= erl_r - 1'b1;
                    end
                end
                default: hold_r <= servo_cycle_pkg::HOLD_CLOSED;
            endcase
        end
    end

    // open loop flag and torque output
    // registered one clock behind the hold state; the loop update strobe
    // reads this flag, so the first cycle after entry is already bypassed
    // torque reads zero while closed, leaving the loop output in charge
    always_ff @(posedge i_ref_clk) begin
        if (i_srst) begin
            o_open_loop <= 1'b0;
            o_torque_limit <= 16'h0000;
        end else begin
            o_open_loop <= (hold_r == servo_cycle_pkg::HOLD_OPEN);
            if (hold_r == servo_cycle_pkg::HOLD_OPEN) begin
                // moving limit until expiry, holding limit after, even mid-move
                o_torque_limit <= (erl_r != '0) ? i_cfg.tq_moving
                                                : i_cfg.tq_holding;
            end else begin
                o_torque_limit <= 16'h0000;
            end
        end
    end

endmodule

`default_nettype wire

// ==== verif/servo_far_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// motor side: generator busy for a span after each start, host offers one byte per poll
module servo_far_model #(
    parameter int unsigned MOVE_CLKS = 600
) (
    input wire logic i_ref_clk,
    input wire logic i_srst,
    input wire logic i_start, // generator start strobe
    input wire logic i_take, // poll strobe from the sequencer
    output logic o_busy, // generator active
    output logic [7:0] o_rx // byte on the serial line
);
    int unsigned left_r; // clocks of the move still to run
    // move timer, restarted by every start
    always_ff @(posedge i_ref_clk) begin
        if (i_srst) begin
            left_r <= 0;
        end else if (i_start) begin
            left_r <= MOVE_CLKS; // move begins
        end else if (left_r != 0) begin
            left_r <= left_r - 1;
        end
    end
    assign o_busy = (left_r != 0);
    // next byte after each poll, so a stale capture shows
    always_ff @(posedge i_ref_clk) begin
        if (i_srst) begin
            o_rx <= 8'h41;
        end else if (i_take) begin
            o_rx <= o_rx + 8'h01; // one byte per period
        end
    end
endmodule
`default_nettype wire

// ==== verif/servo_cycle_sequencer_props.sv ====
`timescale 1ns/1ps
`default_nettype none
// watches slot order, pacing and command gating at the ports
module servo_cycle_sequencer_props #(
    parameter int unsigned CYCLE_LEN = 3000,
    parameter int unsigned POLL_LEN = 1000
) (
    input wire logic i_ref_clk,
    input wire logic i_srst,
    input wire logic i_traj_active,
    input wire logic i_concurrency_on_cmd,
    input wire logic i_concurrency_off_cmd,
    input wire servo_cycle_pkg::task_strobe_t o_task,
    input wire logic o_cmd_fetch,
    input wire logic o_traj_start,
    input wire logic o_concurrency,
    input wire logic o_open_loop,
    input wire logic o_loop_update,
    input wire logic o_serial_take
);
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (i_srst);
    int unsigned gap_r; // clocks since the last loop strobe
    int unsigned pgap_r; // clocks since the last poll strobe
    logic seen_r; // a loop strobe has passed since reset
    // gap counters, cleared by their strobe
    always_ff @(posedge i_ref_clk) begin
        seen_r <= !i_srst && (seen_r || o_task.loop_run);
        gap_r <= (i_srst || o_task.loop_run) ? 0 : gap_r + 1;
        pgap_r <= (i_srst || o_task.serial_poll) ? 0 : pgap_r + 1;
    end
    property p_order;
        o_task.loop_run |-> ##1 o_task.prog_run ##1 o_task.motion_run ##1 o_task.status_run
            ##1 o_task.error_run;
    endproperty
    a_order: assert property (p_order) else $error("task slots out of order"); // slots
    property p_cycle;
        gap_r < CYCLE_LEN && (!(o_task.loop_run && seen_r) || gap_r == CYCLE_LEN - 1);
    endproperty
    a_cycle: assert property (p_cycle) else $error("servo cycle length wrong"); // pace
    property p_poll;
        pgap_r < POLL_LEN && (!(o_task.serial_poll && $past(pgap_r) != 0) || pgap_r == POLL_LEN - 1);
    endproperty
    a_poll: assert property (p_poll) else $error("poll period wrong"); // poll pace
    property p_take;
        o_task.serial_poll |-> o_serial_take;
    endproperty
    a_take: assert property (p_take) else $error("poll without byte take"); // byte
    property p_fetch_slot;
        o_cmd_fetch |-> o_task.prog_run;
    endproperty
    a_fetch_slot: assert property (p_fetch_slot) else $error("fetch outside slot");
    property p_gate;
        o_cmd_fetch |-> $past(o_concurrency) || !$past(i_traj_active);
    endproperty
    a_gate: assert property (p_gate) else $error("fetch during move"); // gating
    property p_on;
        i_concurrency_on_cmd |=> o_concurrency;
    endproperty
    a_on: assert property (p_on) else $error("enable not taken"); // enable
    property p_off;
        i_concurrency_off_cmd && !i_concurrency_on_cmd |=> !o_concurrency;
    endproperty
    a_off: assert property (p_off) else $error("disable not taken"); // disable
    property p_start;
        o_traj_start |-> o_task.motion_run;
    endproperty
    a_start: assert property (p_start) else $error("start outside motion slot");
    property p_loop;
        o_loop_update |-> o_task.loop_run;
    endproperty
    a_loop: assert property (p_loop) else $error("loop update off slot"); // loop
    property p_bypass;
        o_task.loop_run |-> o_loop_update == !$past(o_open_loop);
    endproperty
    a_bypass: assert property (p_bypass) else $error("loop update while open"); // bypass
    property p_rst;
        $past(i_srst) |-> !o_concurrency && !o_open_loop;
    endproperty
    a_rst: assert property (p_rst) else $error("bad state after reset"); // defaults
    c_fetch: cover property (o_cmd_fetch && o_concurrency);
    c_open: cover property ($rose(o_open_loop));
    c_start: cover property (o_traj_start);
endmodule
bind servo_cycle_sequencer servo_cycle_sequencer_props #(.CYCLE_LEN(CYCLE_LEN),
    .POLL_LEN(POLL_LEN)) i_props (.i_ref_clk, .i_srst, .i_traj_active, .i_concurrency_on_cmd,
    .i_concurrency_off_cmd, .o_task, .o_cmd_fetch, .o_traj_start, .o_concurrency, .o_open_loop,
    .o_loop_update, .o_serial_take);
`default_nettype wire

// ==== verif/servo_cycle_sequencer_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
// drives pacing, gating and hold scenarios through the sequencer
module servo_cycle_sequencer_tb;
    localparam int unsigned CL = 24; // short servo cycle
    logic i_ref_clk = 1'b0, i_srst = 1'b1, i_traj_active, i_stop_cond = 1'b0;
    servo_cycle_pkg::hold_cfg_t i_cfg = '0;
    logic [15:0] i_pos_err = 16'h0000, i_cl_torque = 16'h0000, o_torque_limit;
    logic i_cmd_valid = 1'b0, i_cmd_is_motion = 1'b0, i_cmd_is_wait = 1'b0;
    logic i_cmd_wait_done = 1'b0, i_immediate_motion = 1'b0;
    logic i_concurrency_on_cmd = 1'b0, i_concurrency_off_cmd = 1'b0;
    logic [7:0] i_serial_rx, o_serial_byte;
    servo_cycle_pkg::task_strobe_t o_task;
    logic o_cmd_fetch, o_traj_start, o_concurrency, o_open_loop, o_loop_update, o_serial_take;
    int errors = 0, checks = 0, n_loop = 0, n_take = 0, n_fetch = 0, n_start = 0;
    servo_cycle_sequencer #(.CYCLE_LEN(CL), .POLL_LEN(8)) i_dut (.i_ref_clk, .i_srst, .i_cfg,
        .i_pos_err, .i_cl_torque, .i_traj_active, .i_stop_cond, .i_cmd_valid, .i_cmd_is_motion,
        .i_cmd_is_wait, .i_cmd_wait_done, .i_concurrency_on_cmd, .i_concurrency_off_cmd,
        .i_immediate_motion, .i_serial_rx, .o_task, .o_cmd_fetch, .o_traj_start, .o_concurrency,
        .o_open_loop, .o_loop_update, .o_torque_limit, .o_serial_byte, .o_serial_take);
    servo_far_model #(.MOVE_CLKS(600)) i_far (.i_ref_clk, .i_srst, .i_start(o_traj_start),
        .i_take(o_serial_take), .o_busy(i_traj_active), .o_rx(i_serial_rx));
    always #20 i_ref_clk = ~i_ref_clk;
    // strobe counters at the rising edge
    always @(posedge i_ref_clk) begin
        n_loop += (o_task.loop_run === 1'b1);
        n_take += (o_serial_take === 1'b1);
        n_fetch += (o_cmd_fetch === 1'b1);
        n_start += (o_traj_start === 1'b1);
    end
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n * CL) @(negedge i_ref_clk);
    endtask
    task automatic pulse(ref logic s);
        s = 1'b1;
        @(negedge i_ref_clk);
        s = 1'b0;
    endtask
    task automatic t_cycle();
        chk(o_concurrency, 1'b0); // off after reset
        cyc(4);
        chk(n_loop, 4); // one loop per cycle
        chk(n_take, 12); // three polls per cycle
        chk(o_serial_byte, i_serial_rx - 8'h01); // latest byte kept
        $display("test cycle done");
    endtask
    task automatic t_stall();
        int f;
        i_cmd_valid = 1'b1;
        i_cmd_is_motion = 1'b1;
        cyc(1);
        i_cmd_is_motion = 1'b0;
        chk(n_fetch, 1); // motion fetched
        f = n_fetch;
        cyc(3);
        chk(n_fetch - f, 0); // halted during move
        cyc(25);
        chk(n_fetch > f, 1'b1); // resumes after move
        i_cmd_valid = 1'b0;
        $display("test stall done");
    endtask
    task automatic t_conc();
        int f;
        pulse(i_concurrency_on_cmd);
        chk(o_concurrency, 1'b1); // enable
        i_cmd_valid = 1'b1;
        i_cmd_is_motion = 1'b1;
        f = n_fetch;
        cyc(4);
        chk(n_fetch - f, 4); // one per cycle during move
        chk(i_traj_active, 1'b1); // move running
        i_cmd_valid = 1'b0;
        i_cmd_is_motion = 1'b0;
        pulse(i_concurrency_off_cmd);
        chk(o_concurrency, 1'b0); // disable
        f = n_start;
        pulse(i_immediate_motion);
        cyc(1);
        chk(n_start - f, 1); // host move starts
        $display("test concurrency done");
    endtask
    task automatic t_hold();
        i_cfg = '{16'h000a, 16'h0014, 1'b0, 1'b0, 16'h0006, 16'h0003, 16'h0300, 16'h0100};
        i_pos_err = 16'h000a;
        cyc(8);
        chk(o_open_loop, 1'b0); // no hold while moving
        i_cfg.move_mode = 1'b1;
        cyc(4);
        chk(o_open_loop, 1'b0); // settle still running
        cyc(5);
        chk(o_open_loop, 1'b1); // entered at threshold
        chk(o_torque_limit, 16'h0300); // moving limit first
        cyc(4);
        chk(o_torque_limit, 16'h0100); // holding limit after timer
        chk(i_traj_active, 1'b1); // still inside the move
        i_pos_err = 16'h0014;
        cyc(1);
        chk(o_open_loop, 1'b0); // exit at threshold
        i_pos_err = 16'h000a;
        cyc(3);
        i_pos_err = 16'h000b;
        cyc(1);
        i_pos_err = 16'h000a;
        cyc(5);
        chk(o_open_loop, 1'b0); // settle restarted
        cyc(4);
        chk(o_open_loop, 1'b1); // enters after full settle
        i_pos_err = 16'h0014;
        cyc(1);
        i_cfg.check_torque = 1'b1;
        i_cl_torque = 16'h0400;
        i_pos_err = 16'h000a;
        cyc(10);
        chk(o_open_loop, 1'b0); // torque over limit blocks
        i_cl_torque = 16'h0050;
        cyc(10);
        chk(o_open_loop, 1'b1); // torque within limit
        i_pos_err = 16'h0000;
        i_cfg.enter_err = 16'h0000;
        i_cfg.exit_err = 16'h0000;
        cyc(10);
        chk(o_open_loop, 1'b0); // zero thresholds disable
        $display("test hold done");
    endtask
    task automatic t_wait();
        int f;
        pulse(i_concurrency_on_cmd);
        i_cmd_valid = 1'b1;
        for (int k = 0; k < 2; k++) begin
            f = n_fetch;
            i_cmd_is_wait = 1'b1;
            cyc(1);
            i_cmd_is_wait = 1'b0;
            chk(n_fetch - f, 1); // wait command fetched
            cyc(3);
            chk(n_fetch - f, 1); // no fetch while waiting
            if (k == 0) begin
                pulse(i_cmd_wait_done);
            end else begin
                pulse(i_stop_cond);
            end
            cyc(2);
            chk(n_fetch - f > 1, 1'b1); // fetching resumes
        end
        i_cmd_valid = 1'b0;
        $display("test wait done");
    endtask
    task automatic give_verdict();
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    // watchdog sized well past the expected run
    initial begin
        #300000;
        errors++;
        give_verdict();
    end
    // main sequence
    initial begin
        repeat (3) @(posedge i_ref_clk);
        @(negedge i_ref_clk);
        i_srst = 1'b0;
        t_cycle();
        t_stall();
        t_conc();
        t_hold();
        t_wait();
        give_verdict();
    end
endmodule
`default_nettype wire
